// ===== common/psr_pkg.sv
// psr_pkg: constants and types shared by the pressure sensor register block.
// assumes a 40 MHz core clock and a separately clocked link oversampler.
package psr_pkg;
   // register offsets (byte addresses on the serial link)
   localparam logic [7:0] ADDR_COMMAND = 8'h22;
   localparam logic [7:0] ADDR_TEMP = 8'h2E;
   localparam logic [7:0] ADDR_PRESS = 8'h30;
   localparam logic [7:0] ADDR_STAT_SYNC = 8'h32;
   localparam logic [7:0] ADDR_STATUS = 8'h36;
   // command codes and reset value
   localparam logic [15:0] CMD_SLEEP = 16'h6C32;
   localparam logic [15:0] CMD_RESET = 16'hB169;
   localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
   // status bit positions
   localparam int ST_IDLE = 0;
   localparam int ST_S_UP = 3;
   localparam int ST_T_UP = 4;
   localparam int ST_BS_FAIL = 7;
   localparam int ST_BC_FAIL = 8;
   localparam int ST_SAT = 10;
   localparam int ST_CRC_ERR = 11;
   localparam int ST_S_MISS = 14;
   localparam int ST_T_MISS = 15;
   localparam logic [15:0] STATUS_RESET_VAL = 16'h0000;
   // slave address: upper five bits fixed, then strap, then frame type
   localparam logic [4:0] SLAVE_PREFIX = 5'h1B;
   // frame check generators
   localparam logic [3:0] CRC4_POLY = 4'h3;
   localparam logic [3:0] CRC4_INIT = 4'hF;
   localparam logic [7:0] CRC8_POLY = 8'hD5;
   localparam logic [7:0] CRC8_INIT = 8'hFF;
   // largest protected write held before commit, in bytes
   localparam logic [2:0] WBUF_BYTES = 3'h4;
   // crossing request kinds
   typedef enum logic [1:0] {
      REQ_READ = 2'b00,
      REQ_WRITE = 2'b01,
      REQ_CRCERR = 2'b10
   } psr_req_type;
   // link byte engine states
   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_RX = 3'b001,
      L_RXACK = 3'b010,
      L_FETCH = 3'b011,
      L_TX = 3'b100,
      L_TXACK = 3'b101,
      L_COMMIT = 3'b110
   } psr_link_type;
   // position of the received byte in the frame
   typedef enum logic [2:0] {
      F_DEV = 3'b000,
      F_MADDR = 3'b001,
      F_LEN = 3'b010,
      F_DATA = 3'b011,
      F_CRC = 3'b100
   } psr_stage_type;
endpackage

// ===== src/psr_regs.sv
// psr_regs: serial slave and register file of a barometric pressure sensor.
// assumes linkClock oversamples scl at least 16x; measurement and memory
// loader logic run on clock.
// Notes on behaviour
// - sleep code in command enters sleep
// - reset code reloads configuration and rechecks it
// - only status and command stay writable
// - command is write-only, resets to zero
// - new temperature sets temperature-updated flag
// - new pressure sets pressure-updated flag
// - result updates blocked until first configuration load completes
// - failed memory check blocks result updates
// - protected read: length/crc4, data, crc8
// - protected write; status write clears ones
// - all register access via serial link
// - length nibble is bytes minus one, even
// - crc4 poly 0x03, init 0x0F
// - crc8 poly 0xD5, init 0xFF
// - crc mismatch sets crc error flag
`timescale 1ns/1ps
module psr_regs
   import psr_pkg::*;
(
   input wire logic clock, // core clock, 40 MHz
   input wire logic reset_n, // async reset, active low
   input wire logic linkClock, // oversampling clock of the link logic
   input wire logic sclIn, // serial clock pin level
   output logic sclOut, // serial clock drive value, always low
   output logic sclDriveN, // low stretches serial clock
   input wire logic sdaIn, // serial data pin level
   output logic sdaOut, // serial data drive value, always low
   output logic sdaDriveN, // low pulls serial data low
   input wire logic addrStrap, // address select strap pin
   input wire logic tempValid, // new temperature word, one cycle
   input wire logic [15:0] tempData, // corrected temperature
   input wire logic pressValid, // new pressure word, one cycle
   input wire logic [15:0] pressData, // corrected pressure
   input wire logic measIdle, // measurement chain idle level
   input wire logic dspSaturated, // saturation level
   input wire logic supplyFail, // bridge supply failure, one cycle
   input wire logic bridgeFail, // bridge check failure, one cycle
   input wire logic cfgLoadDone, // configuration load finished, one cycle
   input wire logic cfgCrcOk, // configuration check result with done
   output logic cfgReload, // start configuration reload, one cycle
   output logic sleepMode // sleep power state level
);
   // ---------------- link domain ----------------
   logic sclS1, sclS2, sclS3, sdaS1, sdaS2, sdaS3, strapS1, strapS2;
   logic ackS1, ackS2;
   psr_link_type lst_q, lst_d;
   psr_stage_type stg_q, stg_d;
   psr_req_type reqKind_q, reqKind_d;
   logic [3:0] bitCnt_q, bitCnt_d;
   logic [7:0] shift_q, shift_d, memAddr_q, memAddr_d, reqAddr_q, reqAddr_d;
   logic [15:0] reqData_q, reqData_d, rdWord_q, rdWord_d;
   logic [3:0] crc4_q, crc4_d;
   logic [7:0] crc8_q, crc8_d, crcHold_q, crcHold_d;
   logic [7:0] wbuf_q [4];
   logic [7:0] wbuf_d [4];
   logic [2:0] wcnt_q, wcnt_d, widx_q, widx_d;
   logic [4:0] lenLeft_q, lenLeft_d;
   logic crcMode_q, crcMode_d, hiByte_q, hiByte_d, crcTx_q, crcTx_d;
   logic commit_q, commit_d, reqTgl_q, reqTgl_d, sdaN_q, sdaN_d, busy_q, busy_d;
   logic sclRise, sclFall, startC, stopC, linkBusy, crcBit, fb4, fb8;
   logic [7:0] byteIn;
   logic wasRead_q;
   logic reqS1, reqS2, reqS3, actS1, actS2, actS3, reqSeen;
   logic ackTgl_q, ackTgl_d, sleep_q, sleep_d, reload_q, reload_d;
   logic loadPend_q, loadPend_d, cfgFail_q, cfgFail_d, updOk;
   logic [15:0] cmd_q, cmd_d, temp_q, temp_d, press_q, press_d;
   logic [15:0] stat_q, stat_d, rdData_q, rdData_d, statLive, setM, clrM;
   logic [1:0] sync_q, sync_d;

   // pin synchronisers; logic uses the second stage, edge detection also the third
   always_ff @(posedge linkClock or negedge reset_n) begin
      if (!reset_n) begin
         {sclS1, sclS2, sclS3, sdaS1, sdaS2, sdaS3} <= 6'h3F;
         {strapS1, strapS2, ackS1, ackS2} <= 4'h0;
      end else begin
         {sclS1, sclS2, sclS3} <= {sclIn, sclS1, sclS2};
         {sdaS1, sdaS2, sdaS3} <= {sdaIn, sdaS1, sdaS2};
         {strapS1, strapS2} <= {addrStrap, strapS1};
         {ackS1, ackS2} <= {ackTgl_q, ackS1};
      end
   end

   assign sclRise = sclS2 & ~sclS3;
   assign sclFall = ~sclS2 & sclS3;
   assign startC = sclS2 & sclS3 & ~sdaS2 & sdaS3;
   assign stopC = sclS2 & sclS3 & sdaS2 & ~sdaS3;
   assign linkBusy = reqTgl_q ^ ackS2; // request still in flight
   assign byteIn = shift_q;
   assign crcBit = sdaS2;
   assign fb4 = crc4_q[3] ^ crcBit;
   assign fb8 = crc8_q[7] ^ crcBit;

   // link byte engine: receive, acknowledge, fetch, transmit
   always_comb begin
      lst_d = lst_q; stg_d = stg_q; reqKind_d = reqKind_q; bitCnt_d = bitCnt_q;
      shift_d = shift_q; memAddr_d = memAddr_q; reqAddr_d = reqAddr_q;
      reqData_d = reqData_q; rdWord_d = rdWord_q; crc4_d = crc4_q; crc8_d = crc8_q;
      crcHold_d = crcHold_q; wbuf_d = wbuf_q; wcnt_d = wcnt_q; widx_d = widx_q;
      lenLeft_d = lenLeft_q; crcMode_d = crcMode_q; hiByte_d = hiByte_q;
      crcTx_d = crcTx_q; commit_d = commit_q; reqTgl_d = reqTgl_q; sdaN_d = sdaN_q;
      busy_d = busy_q;
      // bus bits feed both checks, except the length byte's crc4 nibble which skips crc4; ack bits excluded
      if (sclRise && (lst_q == L_RX || lst_q == L_TX)) begin
         bitCnt_d = bitCnt_q + 4'h1;
         if (!(stg_q == F_LEN && bitCnt_q >= 4'h4) || lst_q == L_TX)
            crc4_d = {crc4_q[2:0], 1'b0} ^ (fb4 ? CRC4_POLY : 4'h0);
         crc8_d = {crc8_q[6:0], 1'b0} ^ (fb8 ? CRC8_POLY : 8'h00);
         // check value before each byte; a restart pulse must not count as a bit
         if (lst_q == L_RX && bitCnt_q == 4'h0)
            crcHold_d = crc8_q;
         if (lst_q == L_RX)
            shift_d = {shift_q[6:0], sdaS2};
      end
      case (lst_q)
         L_IDLE: ;
         L_RX: begin
            if (sclFall && bitCnt_q == 4'h8) begin
               lst_d = L_RXACK;
               sdaN_d = 1'b0;
               case (stg_q)
                  F_DEV: begin
                     if (byteIn[7:2] != {SLAVE_PREFIX, strapS2}) begin
                        sdaN_d = 1'b1;
                        lst_d = L_IDLE;
                     end else begin
                        crcMode_d = byteIn[1];
                        stg_d = byteIn[0] ? F_DATA : F_MADDR;
                        hiByte_d = 1'b0;
                        crcTx_d = 1'b0;
                     end
                  end
                  F_MADDR: begin
                     memAddr_d = {byteIn[7:1], 1'b0};
                     stg_d = crcMode_q ? F_LEN : F_DATA;
                     wcnt_d = 3'h0;
                  end
                  F_LEN: begin
                     lenLeft_d = {1'b0, byteIn[7:4]} + 5'h01;
                     stg_d = F_DATA;
                     if (byteIn[3:0] != crc4_q) begin
                        sdaN_d = 1'b1;
                        reqKind_d = REQ_CRCERR;
                        reqTgl_d = ~reqTgl_q;
                     end else if (!byteIn[4])
                        sdaN_d = 1'b1;
                  end
                  F_DATA: begin
                     wbuf_d[wcnt_q[1:0]] = byteIn;
                     if (!crcMode_q) begin
                        wcnt_d = {2'b00, ~wcnt_q[0]};
                        if (wcnt_q[0]) begin
                           reqKind_d = REQ_WRITE;
                           reqAddr_d = memAddr_q;
                           reqData_d = {byteIn, wbuf_q[0]};
                           reqTgl_d = ~reqTgl_q;
                           memAddr_d = memAddr_q + 8'h02;
                        end
                     end else if (wcnt_q == WBUF_BYTES) begin
                        sdaN_d = 1'b1;
                     end else begin
                        wcnt_d = wcnt_q + 3'h1;
                        lenLeft_d = lenLeft_q - 5'h01;
                        if (lenLeft_q == 5'h01) begin
                           stg_d = F_CRC;
                           crcHold_d = crc8_q;
                        end
                     end
                  end
                  F_CRC: begin
                     if (byteIn == crcHold_q) begin
                        commit_d = 1'b1;
                     end else begin
                        sdaN_d = 1'b1;
                        reqKind_d = REQ_CRCERR;
                        reqTgl_d = ~reqTgl_q;
                     end
                  end
                  default: lst_d = L_IDLE;
               endcase
            end
         end
         L_RXACK: begin
            if (sclFall) begin
               sdaN_d = 1'b1;
               bitCnt_d = 4'h0;
               if (sdaN_q)
                  lst_d = L_IDLE; // refused byte ends the frame
               else if (commit_q) begin
                  lst_d = L_COMMIT;
                  widx_d = 3'h0;
               end else if (stg_q == F_DATA && crcMode_q == 1'b0 && shift_q[0] && bitCnt_q == 4'h0)
                  lst_d = L_RX;
               else if (stg_q == F_DATA && !commit_q && wasRead_q)
                  lst_d = L_FETCH;
               else
                  lst_d = L_RX;
            end
         end
         L_FETCH: begin
            // hold scl low until the core returns the word
            if (!busy_q) begin
               reqKind_d = REQ_READ;
               reqAddr_d = memAddr_q;
               reqTgl_d = ~reqTgl_q;
               busy_d = 1'b1;
            end else if (!linkBusy) begin
               busy_d = 1'b0;
               rdWord_d = rdData_q;
               shift_d = rdData_q[7:0];
               sdaN_d = rdData_q[7];
               memAddr_d = memAddr_q + 8'h02;
               lst_d = L_TX;
            end
         end
         L_TX: begin
            if (sclFall && bitCnt_q == 4'h8) begin
               sdaN_d = 1'b1;
               lst_d = L_TXACK;
               if (crcMode_q && !crcTx_q)
                  lenLeft_d = lenLeft_q - 5'h01;
            end else if (sclFall) begin
               shift_d = {shift_q[6:0], 1'b0};
               sdaN_d = shift_q[6];
            end
         end
         L_TXACK: begin
            if (sclRise && sdaS2)
               lst_d = L_IDLE; // master refused further data
            else if (sclFall) begin
               bitCnt_d = 4'h0;
               hiByte_d = ~hiByte_q;
               if (crcTx_q)
                  lst_d = L_IDLE;
               else if (crcMode_q && lenLeft_q == 5'h00) begin
                  crcTx_d = 1'b1;
                  shift_d = crc8_q;
                  sdaN_d = crc8_q[7];
                  lst_d = L_TX;
               end else if (!hiByte_q) begin
                  shift_d = rdWord_q[15:8];
                  sdaN_d = rdWord_q[15];
                  lst_d = L_TX;
               end else
                  lst_d = L_FETCH;
            end
         end
         L_COMMIT: begin
            // words leave only after the whole frame checked out
            if (!linkBusy) begin
               if (widx_q >= wcnt_q) begin
                  commit_d = 1'b0;
                  lst_d = L_IDLE;
               end else begin
                  reqKind_d = REQ_WRITE;
                  reqAddr_d = memAddr_q;
                  reqData_d = {wbuf_q[widx_q[1:0] + 2'h1], wbuf_q[widx_q[1:0]]};
                  reqTgl_d = ~reqTgl_q;
                  memAddr_d = memAddr_q + 8'h02;
                  widx_d = widx_q + 3'h2;
               end
            end
         end
         default: lst_d = L_IDLE;
      endcase
      // start restarts the frame except during fetch or commit; a repeated start keeps the running checks
      if (startC && lst_q != L_COMMIT && lst_q != L_FETCH) begin
         if (lst_q == L_IDLE) begin
            crc4_d = CRC4_INIT;
            crc8_d = CRC8_INIT;
         end else if (lst_q == L_RX && bitCnt_q != 4'h0)
            crc8_d = crcHold_q;
         lst_d = L_RX;
         stg_d = F_DEV;
         bitCnt_d = 4'h0;
         sdaN_d = 1'b1;
      end else if (stopC && lst_q != L_COMMIT && lst_q != L_FETCH) begin
         lst_d = L_IDLE;
         sdaN_d = 1'b1;
      end
   end

   // remembers that the address byte asked for a read
   always_ff @(posedge linkClock or negedge reset_n) begin
      if (!reset_n)
         wasRead_q <= 1'b0;
      else if (lst_q == L_RX && stg_q == F_DEV && sclFall && bitCnt_q == 4'h8)
         wasRead_q <= byteIn[0];
   end

   always_ff @(posedge linkClock or negedge reset_n) begin
      if (!reset_n) begin
         lst_q <= L_IDLE; stg_q <= F_DEV; reqKind_q <= REQ_READ; bitCnt_q <= 4'h0;
         shift_q <= 8'h00; memAddr_q <= 8'h00; reqAddr_q <= 8'h00; reqData_q <= 16'h0000;
         rdWord_q <= 16'h0000; crc4_q <= CRC4_INIT; crc8_q <= CRC8_INIT; crcHold_q <= 8'h00;
         wbuf_q <= '{default: 8'h00}; wcnt_q <= 3'h0; widx_q <= 3'h0; lenLeft_q <= 5'h00;
         crcMode_q <= 1'b0; hiByte_q <= 1'b0; crcTx_q <= 1'b0; commit_q <= 1'b0;
         reqTgl_q <= 1'b0; sdaN_q <= 1'b1; busy_q <= 1'b0;
      end else begin
         lst_q <= lst_d; stg_q <= stg_d; reqKind_q <= reqKind_d; bitCnt_q <= bitCnt_d;
         shift_q <= shift_d; memAddr_q <= memAddr_d; reqAddr_q <= reqAddr_d; reqData_q <= reqData_d;
         rdWord_q <= rdWord_d; crc4_q <= crc4_d; crc8_q <= crc8_d; crcHold_q <= crcHold_d;
         wbuf_q <= wbuf_d; wcnt_q <= wcnt_d; widx_q <= widx_d; lenLeft_q <= lenLeft_d;
         crcMode_q <= crcMode_d; hiByte_q <= hiByte_d; crcTx_q <= crcTx_d; commit_q <= commit_d;
         reqTgl_q <= reqTgl_d; sdaN_q <= sdaN_d; busy_q <= busy_d;
      end
   end

   // open-drain pins: drive value is always low, enables carry the data
   assign sdaOut = 1'b0;
   assign sclOut = 1'b0;
   assign sdaDriveN = sdaN_q;
   assign sclDriveN = ~(lst_q == L_FETCH); // stretch while the word is fetched

   // ---------------- core domain ----------------

   // crossings into the core: request toggle and bus activity level
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         {reqS1, reqS2, reqS3, actS1, actS2, actS3} <= 6'h00;
      else
         {reqS1, reqS2, reqS3, actS1, actS2, actS3} <= {reqTgl_q, reqS1, reqS2, ~(lst_q == L_IDLE), actS1, actS2};
   end

   assign reqSeen = reqS2 ^ reqS3;
   assign updOk = ~loadPend_q & ~cfgFail_q;
   assign statLive = stat_q | {5'h00, dspSaturated, 9'h000, measIdle};

   // register file reached only through link requests
   always_comb begin
      ackTgl_d = ackTgl_q; sleep_d = sleep_q; reload_d = 1'b0; loadPend_d = loadPend_q;
      cfgFail_d = cfgFail_q; cmd_d = cmd_q; temp_d = temp_q; press_d = press_q;
      rdData_d = rdData_q; sync_d = sync_q; setM = 16'h0000; clrM = 16'h0000;
      if (tempValid && updOk) begin
         temp_d = tempData;
         setM[ST_T_UP] = 1'b1;
         setM[ST_T_MISS] = stat_q[ST_T_UP];
      end
      if (pressValid && updOk) begin
         press_d = pressData;
         setM[ST_S_UP] = 1'b1;
         setM[ST_S_MISS] = stat_q[ST_S_UP];
      end
      setM[ST_BS_FAIL] = supplyFail;
      setM[ST_BC_FAIL] = bridgeFail;
      if (cfgLoadDone) begin
         loadPend_d = 1'b0;
         cfgFail_d = ~cfgCrcOk;
      end
      if (sleep_q && actS2 && !actS3)
         sleep_d = 1'b0; // bus activity wakes the part
      if (reqSeen) begin
         ackTgl_d = ~ackTgl_q;
         case (reqKind_q)
            REQ_READ: begin
               case (reqAddr_q)
                  ADDR_TEMP: begin
                     rdData_d = temp_q;
                     sync_d[1] = stat_q[ST_T_UP];
                     clrM[ST_T_UP] = 1'b1;
                  end
                  ADDR_PRESS: begin
                     rdData_d = press_q;
                     sync_d[0] = stat_q[ST_S_UP];
                     clrM[ST_S_UP] = 1'b1;
                  end
                  ADDR_STAT_SYNC: rdData_d = {statLive[15:5], sync_q, statLive[2:0]};
                  ADDR_STATUS: rdData_d = statLive;
                  default: rdData_d = 16'h0000;
               endcase
            end
            REQ_WRITE: begin
               if (reqAddr_q == ADDR_COMMAND) begin
                  cmd_d = reqData_q;
                  if (reqData_q == CMD_SLEEP)
                     sleep_d = 1'b1;
                  if (reqData_q == CMD_RESET) begin
                     reload_d = 1'b1;
                     loadPend_d = 1'b1;
                     cfgFail_d = 1'b0;
                  end
               end else if (reqAddr_q == ADDR_STATUS)
                  clrM = reqData_q;
            end
            REQ_CRCERR: setM[ST_CRC_ERR] = 1'b1;
            default: ;
         endcase
      end
      // a new event wins over a clear in the same cycle
      stat_d = (stat_q & ~clrM) | setM;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ackTgl_q <= 1'b0; sleep_q <= 1'b0; reload_q <= 1'b0; loadPend_q <= 1'b1;
         cfgFail_q <= 1'b0; cmd_q <= CMD_RESET_VAL; temp_q <= 16'h0000; press_q <= 16'h0000;
         stat_q <= STATUS_RESET_VAL; rdData_q <= 16'h0000; sync_q <= 2'b00;
      end else begin
         ackTgl_q <= ackTgl_d; sleep_q <= sleep_d; reload_q <= reload_d; loadPend_q <= loadPend_d;
         cfgFail_q <= cfgFail_d; cmd_q <= cmd_d; temp_q <= temp_d; press_q <= press_d;
         stat_q <= stat_d; rdData_q <= rdData_d; sync_q <= sync_d;
      end
   end

   assign cfgReload = reload_q;
   assign sleepMode = sleep_q;

   // checks on the core side
   sequence cmdWr(logic [15:0] code);
      reqSeen && reqKind_q == REQ_WRITE && reqAddr_q == ADDR_COMMAND && reqData_q == code;
   endsequence
   sleep_entry_a: assert property (@(posedge clock) disable iff (!reset_n) cmdWr(CMD_SLEEP) |=> sleep_q)
      else $error("sleep code did not enter sleep");
   reload_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
      cmdWr(CMD_RESET) |=> cfgReload ##1 !cfgReload && loadPend_q)
      else $error("reset code did not give one reload pulse");
   protect_sync_a: assert property (@(posedge clock) disable iff (!reset_n)
      reqSeen && reqKind_q == REQ_WRITE && reqAddr_q == ADDR_TEMP |=> temp_q == $past(temp_q) || $past(tempValid))
      else $error("protected register was written");
   temp_flag_a: assert property (@(posedge clock) disable iff (!reset_n) tempValid && updOk |=> stat_q[ST_T_UP])
      else $error("temperature update flag not set");
   press_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
      pressValid && updOk |=> stat_q[ST_S_UP] && press_q == $past(pressData))
      else $error("pressure update not loaded");
   no_update_a: assert property (@(posedge clock) disable iff (!reset_n)
      (cfgFail_q || loadPend_q) && !cfgLoadDone [*2] |-> $stable(temp_q) && $stable(press_q))
      else $error("result changed after failed memory check");
   crc_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
      reqSeen && reqKind_q == REQ_CRCERR |=> stat_q[ST_CRC_ERR])
      else $error("crc error flag not set");
   // checks on the link side
   len_nack_a: assert property (@(posedge linkClock) disable iff (!reset_n)
      lst_q == L_RX && stg_q == F_LEN && sclFall && bitCnt_q == 4'h8 && !byteIn[4] |=> sdaN_q)
      else $error("odd byte length was acknowledged");
   commit_only_a: assert property (@(posedge linkClock) disable iff (!reset_n)
      $rose(commit_q) |-> $past(shift_q) == $past(crcHold_q))
      else $error("protected write committed without match");
endmodule

// ===== dv/psr_i2c_master.sv
// psr_i2c_master: bit-level serial bus master used by the bench.
// assumes wired-and lines with pull-ups resolved in the bench.
`timescale 1ns/1ps
module psr_i2c_master (
   input wire logic linkClock, // pacing clock
   input wire logic sclLine, // resolved clock line
   input wire logic sdaLine, // resolved data line
   output logic sclM = 1'h1, // low pulls clock line
   output logic sdaM = 1'h1 // low pulls data line
);
   // one phase step; 10 edges keeps the bit period above the 16-clock minimum
   task lv(input logic c, input logic d);
      sclM <= c;
      sdaM <= d;
      repeat (10) @(posedge linkClock);
   endtask
   // clock goes low before data moves, so no false start or stop is seen
   task start();
      lv(1'h0, sdaM);
      lv(1'h0, 1'h1);
      lv(1'h1, 1'h1);
      lv(1'h1, 1'h0);
   endtask
   task stop();
      lv(1'h0, sdaM);
      lv(1'h0, 1'h0);
      lv(1'h1, 1'h0);
      lv(1'h1, 1'h1);
   endtask
   // eight bits msb first plus ack slot; waits out clock stretching
   task xfer(input logic [8:0] d, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         lv(1'h0, sdaM);
         lv(1'h0, d[i]);
         lv(1'h1, d[i]);
         while (!sclLine) @(posedge linkClock);
         r[i] = sdaLine;
      end
   endtask
endmodule

// ===== dv/psr_regs_tb_top.sv
// psr_regs_tb_top: self-checking bench for the sensor register block.
// assumes the master model paces the link; results arrive on the core clock.
`timescale 1ns/1ps
module psr_regs_tb_top;
   import psr_pkg::*;
   logic clock = 1'h0, linkClock = 1'h0, reset_n = 1'h0, tempValid = 1'h0, pressValid = 1'h0;
   logic cfgLoadDone = 1'h0, cfgCrcOk = 1'h0, measIdle = 1'h0;
   logic [15:0] tempData = 16'h0000, pressData = 16'h0000, tv, pv, w;
   logic [7:0] c8, b;
   logic [8:0] r9;
   logic [31:0] s = 32'h00006299;
   wire sclOut, sclDriveN, sdaOut, sdaDriveN, cfgReload, sleepMode, sclM, sdaM;
   int failures = 0, samplesChecked = 0, reloads = 0;
   // open-drain lines with pull-ups
   wire sclLine = sclM & (sclDriveN | sclOut);
   wire sdaLine = sdaM & (sdaDriveN | sdaOut);
   initial forever #12.5 clock = ~clock;
   initial begin
      #3;
      forever #15 linkClock = ~linkClock;
   end
   always @(posedge clock) if (cfgReload === 1'h1) reloads++;
   psr_i2c_master mst (.linkClock(linkClock), .sclLine(sclLine), .sdaLine(sdaLine), .sclM(sclM), .sdaM(sdaM));
   psr_regs dut_u (.clock(clock), .reset_n(reset_n), .linkClock(linkClock), .sclIn(sclLine), .sclOut(sclOut),
      .sclDriveN(sclDriveN), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaDriveN(sdaDriveN), .addrStrap(1'h0),
      .tempValid(tempValid), .tempData(tempData), .pressValid(pressValid), .pressData(pressData),
      .measIdle(measIdle), .dspSaturated(1'h0), .supplyFail(1'h0), .bridgeFail(1'h0),
      .cfgLoadDone(cfgLoadDone), .cfgCrcOk(cfgCrcOk), .cfgReload(cfgReload), .sleepMode(sleepMode));
   function logic [15:0] rnd();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s[15:0];
   endfunction
   function logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--) c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? CRC8_POLY : 8'h00);
      return c;
   endfunction
   // length nibble plus check over address byte, memory address and length
   function logic [7:0] lenByte(input logic [7:0] a, input logic [3:0] n);
      logic [3:0] c;
      logic [19:0] v;
      c = CRC4_INIT;
      v = {8'hDA, a, n};
      for (int i = 19; i >= 0; i--) c = {c[2:0], 1'h0} ^ ((c[3] ^ v[i]) ? CRC4_POLY : 4'h0);
      return {n, c};
   endfunction
   task ck(input string n, input logic [15:0] seen, input logic [15:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task tx(input logic [7:0] d);
      mst.xfer({d, 1'h1}, r9);
      c8 = crc8(c8, d);
   endtask
   task rx(input logic n, output logic [7:0] d);
      mst.xfer({8'hFF, n}, r9);
      d = r9[8:1];
      c8 = crc8(c8, d);
   endtask
   task rd(input logic [7:0] a, output logic [15:0] v);
      mst.start();
      tx(8'hD8);
      tx(a);
      mst.start();
      tx(8'hD9);
      rx(1'h0, v[7:0]);
      rx(1'h1, v[15:8]);
      mst.stop();
   endtask
   task wr(input logic [7:0] a, input logic [15:0] v);
      mst.start();
      tx(8'hD8);
      tx(a);
      tx(v[7:0]);
      tx(v[15:8]);
      mst.stop();
      repeat (20) @(posedge clock);
   endtask
   // protected write; a nonzero bad corrupts the trailing check byte
   task pw(input logic [7:0] a, input logic [15:0] v, input logic [7:0] bad);
      c8 = CRC8_INIT;
      mst.start();
      tx(8'hDA);
      tx(a);
      tx(lenByte(a, 4'h1));
      tx(v[7:0]);
      tx(v[15:8]);
      tx(c8 ^ bad);
      ck("write ack", r9[0], bad != 8'h00);
      mst.stop();
      repeat (20) @(posedge clock);
   endtask
   task meas(input logic [15:0] t, input logic [15:0] p);
      @(posedge clock);
      tempData <= t;
      pressData <= p;
      tempValid <= 1'h1;
      pressValid <= 1'h1;
      @(posedge clock);
      tempValid <= 1'h0;
      pressValid <= 1'h0;
      repeat (10) @(posedge clock);
   endtask
   task load(input logic ok);
      @(posedge clock);
      cfgCrcOk <= ok;
      cfgLoadDone <= 1'h1;
      @(posedge clock);
      cfgLoadDone <= 1'h0;
   endtask
   task testDone();
      $display("checks %0d failures %0d", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clock);
      reset_n <= 1'h1;
      load(1'h1);
      tv = rnd();
      pv = rnd();
      w = rnd();
      measIdle <= w[0];
      meas(tv, pv);
      rd(ADDR_STATUS, w);
      ck("both updated", w[4:3], 2'h3);
      c8 = CRC8_INIT;
      mst.start();
      tx(8'hDA);
      tx(ADDR_TEMP);
      tx(lenByte(ADDR_TEMP, 4'h5));
      mst.start();
      tx(8'hDB);
      for (int i = 0; i < 6; i++) begin
         rx(1'h0, b);
         w = i < 2 ? tv : i < 4 ? pv : {11'h000, 2'h3, 2'h0, measIdle};
         ck("result byte", b, i % 2 ? w[15:8] : w[7:0]);
      end
      w = c8;
      rx(1'h1, b);
      ck("read crc8", b, w);
      mst.stop();
      pw(ADDR_STATUS, 16'hFFFF, 8'h00);
      rd(ADDR_STATUS, w);
      ck("status", w, {15'h0000, measIdle});
      pw(ADDR_COMMAND, CMD_SLEEP, 8'h5A);
      ck("sleep kept", sleepMode, 1'h0);
      rd(ADDR_STATUS, w);
      ck("crc error", w, {4'h0, 1'h1, 10'h000, measIdle});
      wr(ADDR_TEMP, ~tv);
      rd(ADDR_TEMP, w);
      ck("read-only", w, tv);
      rd(ADDR_COMMAND, w);
      ck("command", w, CMD_RESET_VAL);
      wr(ADDR_COMMAND, CMD_SLEEP);
      ck("sleep", sleepMode, 1'h1);
      wr(ADDR_COMMAND, CMD_RESET);
      ck("reloads", reloads[15:0], 16'h0001);
      meas(~tv, ~pv);
      rd(ADDR_TEMP, w);
      ck("blocked", w, tv);
      load(1'h0);
      meas(~tv, ~pv);
      rd(ADDR_PRESS, w);
      ck("crc fail", w, pv);
      testDone();
   end
   // watchdog, about two and a half times the expected run length
   initial begin
      repeat (60000) @(posedge clock);
      failures++;
      testDone();
   end
endmodule
